// File: pkg/tac_pkg.sv
package tac_pkg;

  // ************************************************************
  // Register location and field layout
  // ************************************************************
  localparam logic [1:0] CTRL_PAGE = 2'h1;
  localparam logic [5:0] CTRL_ADDR = 6'h00;
  localparam int PEN_BIT   = 15;
  localparam int STOP_BIT  = 14;
  localparam int FUNC_HI   = 13;
  localparam int FUNC_LO   = 10;
  localparam int RES_HI    = 9;
  localparam int RES_LO    = 8;
  localparam int AVG_HI    = 7;
  localparam int AVG_LO    = 6;
  localparam int CCLK_HI   = 5;
  localparam int CCLK_LO   = 4;
  localparam int SETTLE_HI = 3;
  localparam int SETTLE_LO = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic       MODE_RST   = 1'b0;
  localparam logic       STOP_RST   = 1'b0;
  localparam logic [3:0] FUNC_RST   = 4'h0;
  localparam logic [1:0] RES_RST    = 2'h0;
  localparam logic [1:0] AVG_RST    = 2'h0;
  localparam logic [1:0] CCLK_RST   = 2'h0;
  localparam logic [2:0] SETTLE_RST = 3'h0;
  localparam logic       RSVD_READ  = 1'b0;

  // ************************************************************
  // Function codes, measurements, panel driver patterns
  // ************************************************************
  typedef enum logic [3:0] {
    FN_INVALID = 4'h0, FN_SCAN_XY = 4'h1, FN_SCAN_XYZ = 4'h2,
    FN_X = 4'h3, FN_Y = 4'h4, FN_Z = 4'h5, FN_BATTERY_ONE_RESULT = 4'h6,
    FN_BATTERY_TWO_RESULT = 4'h7, FN_AUXILIARY_ONE_RESULT = 4'h8, FN_AUXILIARY_TWO_RESULT = 4'h9,
    FN_TEMP1 = 4'ha, FN_PORT = 4'hb, FN_TEMP2 = 4'hc,
    FN_DRV_X = 4'hd, FN_DRV_Y = 4'he, FN_DRV_YX = 4'hf
  } tac_func_t;

  // Measurement code doubles as result register index on page 0
  typedef enum logic [3:0] {
    M_X = 4'h0, M_Y = 4'h1, M_Z1 = 4'h2, M_Z2 = 4'h3,
    M_BATTERY_ONE_RESULT = 4'h4, M_BATTERY_TWO_RESULT = 4'h5, M_AUXILIARY_ONE_RESULT = 4'h6, M_AUXILIARY_TWO_RESULT = 4'h7,
    M_TEMP1 = 4'h8, M_TEMP2 = 4'h9
  } tac_meas_t;

  // Driver enables ordered {x_pos, x_neg, y_pos, y_neg}
  localparam logic [3:0] DRV_OFF = 4'h0;
  localparam logic [3:0] DRV_X   = 4'hc;
  localparam logic [3:0] DRV_Y   = 4'h3;
  localparam logic [3:0] DRV_YX  = 4'h6;

  localparam logic [1:0] RES_8  = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] AVG_4  = 2'h1;
  localparam logic [1:0] AVG_8  = 2'h2;
  localparam logic [1:0] AVG_16 = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_100US_NS    = 100_000;
  localparam int T_500US_NS    = 500_000;
  localparam int T_1MS_NS      = 1_000_000;
  localparam int T_5MS_NS      = 5_000_000;
  localparam int T_10MS_NS     = 10_000_000;
  localparam int T_50MS_NS     = 50_000_000;
  localparam int T_100MS_NS    = 100_000_000;
  localparam int TMR_W         = 23;

endpackage : tac_pkg

// File: rtl/tac_settle_timer.sv
`timescale 1ns/1ps
// ************************************************************
// Panel settling down-counter
// ************************************************************
module tac_settle_timer
  import tac_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  output logic                  expired
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // Load wins over counting; zero means no wait at all
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = load_val;
    else if (cnt_q != '0)
      cnt_d = cnt_q - TMR_W'(1);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (ce)
      cnt_q <= cnt_d;
  end

  assign expired = (cnt_q == '0);

endmodule : tac_settle_timer

// File: rtl/tac_control.sv
`timescale 1ns/1ps
// Functional notes
// - Bit 15 reads 1 while the panel is touched, 0 otherwise.
// - Bit 15 written 0 means host-run scans, 1 means self-run on touch.
// - Bit 14 reads 0 while converting, 1 when idle, 1 after reset.
// - Writing 1 to bit 14 aborts everything and powers the converter down.
// - Writing 0 to bit 14 runs normally; scans repeat until pen lifts.
// - Bits 13:10 pick the function; code 0 is invalid and writes nothing.
// - Code 1 repeatedly converts X then Y.
// - Code 2 repeatedly converts X, Y, Z1 and Z2.
// - Codes 3, 4, 5 convert X alone, Y alone, or Z1 and Z2 once.
// - Codes 6 to 9 convert battery one, two, auxiliary one, two.
// - Code 10 measures temperature one, code 12 differential temperature two.
// - Code 11 scans both battery and both auxiliary inputs in turn.
// - Codes 13, 14, 15 only turn on X pair, Y pair, Y pos with X neg.
// - Bits 9:8 give 12-bit for 0 and 3, 8-bit for 1, 10-bit for 2.
// - One converter is shared; each result goes to its own register.
// - Bits 7:6 average 1, 4, 8 or 16 conversions; busy until done.
// - Bits 5:4 select the conversion clock passed to the converter.
// - Self-run waits the bits 3:1 settling delay before sampling.
module tac_control
  import tac_pkg::*;
#(
  parameter int SETTLE_100US_CYC = (T_100US_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_500US_CYC = (T_500US_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_1MS_CYC   = (T_1MS_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_5MS_CYC   = (T_5MS_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_10MS_CYC  = (T_10MS_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_50MS_CYC  = (T_50MS_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS,
  parameter int SETTLE_100MS_CYC = (T_100MS_NS+CLK_PERIOD_NS-1)/CLK_PERIOD_NS
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        pen_touch,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [1:0]  reg_page,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic             conv_start,
  output logic      [3:0]  conv_sel,
  output logic      [1:0]  conv_res,
  output logic      [1:0]  conv_clock_sel,
  output logic             adc_power_on,
  output logic             adc_busy,
  output logic      [3:0]  drv_en,
  output logic             result_wr,
  output logic      [3:0]  result_sel,
  output logic      [11:0] result_data
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic [3:0] meas_of(input logic [3:0] f,
                                         input logic [1:0] s);
    case (f)
      FN_SCAN_XY:  meas_of = (s == 2'h0) ? M_X : M_Y;
      FN_SCAN_XYZ: meas_of = (s == 2'h0) ? M_X : (s == 2'h1) ? M_Y :
                             (s == 2'h2) ? M_Z1 : M_Z2;
      FN_X:        meas_of = M_X;
      FN_Y:        meas_of = M_Y;
      FN_Z:        meas_of = (s == 2'h0) ? M_Z1 : M_Z2;
      FN_BATTERY_ONE_RESULT:     meas_of = M_BATTERY_ONE_RESULT;
      FN_BATTERY_TWO_RESULT:     meas_of = M_BATTERY_TWO_RESULT;
      FN_AUXILIARY_ONE_RESULT:     meas_of = M_AUXILIARY_ONE_RESULT;
      FN_AUXILIARY_TWO_RESULT:     meas_of = M_AUXILIARY_TWO_RESULT;
      FN_TEMP1:    meas_of = M_TEMP1;
      FN_TEMP2:    meas_of = M_TEMP2;
      FN_PORT:     meas_of = (s == 2'h0) ? M_BATTERY_ONE_RESULT : (s == 2'h1) ? M_BATTERY_TWO_RESULT :
                             (s == 2'h2) ? M_AUXILIARY_ONE_RESULT : M_AUXILIARY_TWO_RESULT;
      default:     meas_of = M_X;
    endcase
  endfunction : meas_of

  function automatic logic [1:0] last_step(input logic [3:0] f);
    case (f)
      FN_SCAN_XY, FN_Z:     last_step = 2'h1;
      FN_SCAN_XYZ, FN_PORT: last_step = 2'h3;
      default:              last_step = 2'h0;
    endcase
  endfunction : last_step

  function automatic logic is_conv(input logic [3:0] f);
    is_conv = (f >= FN_SCAN_XY) && (f <= FN_TEMP2);
  endfunction : is_conv

  function automatic logic [3:0] drive_of(input logic [3:0] m);
    case (m)
      M_X:        drive_of = DRV_X;
      M_Y:        drive_of = DRV_Y;
      M_Z1, M_Z2: drive_of = DRV_YX;
      default:    drive_of = DRV_OFF;
    endcase
  endfunction : drive_of

  function automatic logic [4:0] avg_total(input logic [1:0] a);
    case (a)
      AVG_4:   avg_total = 5'h04;
      AVG_8:   avg_total = 5'h08;
      AVG_16:  avg_total = 5'h10;
      default: avg_total = 5'h01;
    endcase
  endfunction : avg_total

  function automatic logic [2:0] avg_shift(input logic [1:0] a);
    case (a)
      AVG_4:   avg_shift = 3'h2;
      AVG_8:   avg_shift = 3'h3;
      AVG_16:  avg_shift = 3'h4;
      default: avg_shift = 3'h0;
    endcase
  endfunction : avg_shift

  // Results stay right-justified at the chosen width
  function automatic logic [2:0] res_shift(input logic [1:0] r);
    case (r)
      RES_8:   res_shift = 3'h4;
      RES_10:  res_shift = 3'h2;
      default: res_shift = 3'h0;
    endcase
  endfunction : res_shift

  function automatic logic [TMR_W-1:0] settle_cyc(input logic [2:0] c);
    case (c)
      3'h1:    settle_cyc = TMR_W'(SETTLE_100US_CYC);
      3'h2:    settle_cyc = TMR_W'(SETTLE_500US_CYC);
      3'h3:    settle_cyc = TMR_W'(SETTLE_1MS_CYC);
      3'h4:    settle_cyc = TMR_W'(SETTLE_5MS_CYC);
      3'h5:    settle_cyc = TMR_W'(SETTLE_10MS_CYC);
      3'h6:    settle_cyc = TMR_W'(SETTLE_50MS_CYC);
      3'h7:    settle_cyc = TMR_W'(SETTLE_100MS_CYC);
      default: settle_cyc = '0;
    endcase
  endfunction : settle_cyc

  // ************************************************************
  // Pen pin synchroniser
  // ************************************************************
  logic pen_meta_q;
  logic pen_q;

  // Pin is asynchronous to clock, two stages before any use
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pen_meta_q <= 1'b0;
      pen_q      <= 1'b0;
    end
    else if (ce)
    begin
      pen_meta_q <= pen_touch;
      pen_q      <= pen_meta_q;
    end
  end

  // ************************************************************
  // Control register and sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_START, ST_WAIT, ST_STORE
  } tac_state_t;

  tac_state_t       st_q,     st_d;
  logic             mode_q,   mode_d;
  logic             stop_q,   stop_d;
  logic [3:0]       func_q,   func_d;
  logic [1:0]       res_q,    res_d;
  logic [1:0]       avg_q,    avg_d;
  logic [1:0]       cclk_q,   cclk_d;
  logic [2:0]       settle_q, settle_d;
  logic [1:0]       step_q,   step_d;
  logic [4:0]       nconv_q,  nconv_d;
  logic [15:0]      acc_q,    acc_d;
  logic [15:0]      rdata_q,  rdata_d;
  logic [3:0]       drv_q,    drv_d;
  logic [3:0]       sel_q,    sel_d;
  logic             start_q,  start_d;
  logic             rwr_q,    rwr_d;
  logic [3:0]       rsel_q,   rsel_d;
  logic [11:0]      rdat_q,   rdat_d;
  logic             hit;
  logic             wr_hit;
  logic             abort;
  logic             go;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;
  logic [3:0]       meas;
  logic [15:0]      avg_val;

  assign hit    = (reg_page == CTRL_PAGE) && (reg_addr == CTRL_ADDR);
  assign wr_hit = reg_wr_en && hit;
  assign abort  = wr_hit && reg_wdata[STOP_BIT];
  assign meas   = meas_of(func_q, step_q);

  // Host-run start on write, self-run start on touch while idle
  assign go = wr_hit && !reg_wdata[STOP_BIT] && !reg_wdata[PEN_BIT] &&
              is_conv(reg_wdata[FUNC_HI:FUNC_LO]) ||
              (st_q == ST_IDLE) && mode_q && !stop_q && pen_q &&
              (func_q >= FN_SCAN_XY) && (func_q <= FN_Z) && !wr_hit;

  always_comb
  begin
    mode_d   = mode_q;
    stop_d   = stop_q;
    func_d   = func_q;
    res_d    = res_q;
    avg_d    = avg_q;
    cclk_d   = cclk_q;
    settle_d = settle_q;
    st_d     = st_q;
    step_d   = step_q;
    nconv_d  = nconv_q;
    acc_d    = acc_q;
    start_d  = 1'b0;
    rwr_d    = 1'b0;
    rsel_d   = rsel_q;
    rdat_d   = rdat_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    avg_val  = acc_q >> avg_shift(avg_q);
    // Fields are stored verbatim; bit 0 is never kept
    if (wr_hit)
    begin
      mode_d   = reg_wdata[PEN_BIT];
      stop_d   = reg_wdata[STOP_BIT];
      func_d   = reg_wdata[FUNC_HI:FUNC_LO];
      res_d    = reg_wdata[RES_HI:RES_LO];
      avg_d    = reg_wdata[AVG_HI:AVG_LO];
      cclk_d   = reg_wdata[CCLK_HI:CCLK_LO];
      settle_d = reg_wdata[SETTLE_HI:SETTLE_LO];
    end
    // Readback carries live pen and idle status
    rdata_d = rdata_q;
    if (reg_rd_en && hit)
      rdata_d = {pen_q, st_q == ST_IDLE, func_q, res_q,
                 avg_q, cclk_q, settle_q, RSVD_READ};
    case (st_q)
      ST_IDLE:
      begin
        if (go)
        begin
          st_d     = ST_SETTLE;
          step_d   = 2'h0;
          tmr_load = 1'b1;
        end
      end
      ST_SETTLE:
      begin
        nconv_d = '0;
        acc_d   = '0;
        if (tmr_done)
          st_d = ST_START;
      end
      ST_START:
      begin
        start_d = 1'b1;
        st_d    = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (conv_done)
        begin
          acc_d   = acc_q + 16'(conv_data);
          nconv_d = nconv_q + 5'h01;
          // Busy holds through every averaged conversion
          st_d = (nconv_d == avg_total(avg_q)) ? ST_STORE : ST_START;
        end
      end
      ST_STORE:
      begin
        rwr_d    = 1'b1;
        rsel_d   = meas;
        rdat_d   = 12'(avg_val) >> res_shift(res_q);
        tmr_load = 1'b1;
        if (step_q != last_step(func_q))
        begin
          step_d = step_q + 2'h1;
          st_d   = ST_SETTLE;
        end
        else if ((func_q == FN_SCAN_XY || func_q == FN_SCAN_XYZ) && pen_q)
        begin
          step_d = 2'h0;
          st_d   = ST_SETTLE;
        end
        else
        begin
          st_d     = ST_IDLE;
          tmr_load = 1'b0;
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    // Settle only panel measurements in self-run mode
    if (tmr_load && mode_d && meas_of(func_d, step_d) <= M_Z2)
      tmr_val = settle_cyc(settle_d);
    if (abort)
    begin
      st_d    = ST_IDLE;
      start_d = 1'b0;
      rwr_d   = 1'b0;
    end
    // Drive-only codes hold their pair while idle
    drv_d = (st_d == ST_IDLE) ? DRV_OFF : drive_of(meas_of(func_d, step_d));
    if (st_d == ST_IDLE && !stop_d)
      case (func_d)
        FN_DRV_X:  drv_d = DRV_X;
        FN_DRV_Y:  drv_d = DRV_Y;
        FN_DRV_YX: drv_d = DRV_YX;
        default:   drv_d = DRV_OFF;
      endcase
    sel_d = meas_of(func_d, step_d);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q     <= ST_IDLE;
      mode_q   <= MODE_RST;
      stop_q   <= STOP_RST;
      func_q   <= FUNC_RST;
      res_q    <= RES_RST;
      avg_q    <= AVG_RST;
      cclk_q   <= CCLK_RST;
      settle_q <= SETTLE_RST;
      step_q   <= 2'h0;
      nconv_q  <= 5'h00;
      acc_q    <= 16'h0000;
      rdata_q  <= 16'h0000;
      drv_q    <= DRV_OFF;
      sel_q    <= 4'h0;
      start_q  <= 1'b0;
      rwr_q    <= 1'b0;
      rsel_q   <= 4'h0;
      rdat_q   <= 12'h000;
    end
    else if (ce)
    begin
      st_q     <= st_d;
      mode_q   <= mode_d;
      stop_q   <= stop_d;
      func_q   <= func_d;
      res_q    <= res_d;
      avg_q    <= avg_d;
      cclk_q   <= cclk_d;
      settle_q <= settle_d;
      step_q   <= step_d;
      nconv_q  <= nconv_d;
      acc_q    <= acc_d;
      rdata_q  <= rdata_d;
      drv_q    <= drv_d;
      sel_q    <= sel_d;
      start_q  <= start_d;
      rwr_q    <= rwr_d;
      rsel_q   <= rsel_d;
      rdat_q   <= rdat_d;
    end
  end

  tac_settle_timer u_settle (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_done)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata      = rdata_q;
  assign conv_start     = start_q;
  assign conv_sel       = sel_q;
  assign conv_res       = res_q;
  assign conv_clock_sel = cclk_q;
  assign adc_busy       = (st_q != ST_IDLE);
  assign adc_power_on   = (st_q != ST_IDLE); // Powered only while working
  assign drv_en         = drv_q;
  assign result_wr      = rwr_q;
  assign result_sel     = rsel_q;
  assign result_data    = rdat_q;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [4:0] hcnt_q;

  // Counts converter starts of the group being averaged
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hcnt_q <= 5'h00;
    else if (ce)
      hcnt_q <= (rwr_q || st_q == ST_IDLE) ? 5'h00 : hcnt_q + 5'(start_q);
  end

  chk_pen_readback: assert property (@(posedge clock) disable iff (rst)
    ce && reg_rd_en && hit |=> reg_rdata[PEN_BIT] == $past(pen_q))
    else $error("pen status readback wrong");
  chk_idle_readback: assert property (@(posedge clock) disable iff (rst)
    ce && reg_rd_en && hit |=> reg_rdata[STOP_BIT] == !$past(adc_busy))
    else $error("busy status readback wrong");
  chk_stop_abort: assert property (@(posedge clock) disable iff (rst)
    ce && abort |=> !adc_power_on && !conv_start && !result_wr)
    else $error("stop did not abort");
  chk_invalid_quiet: assert property (@(posedge clock) disable iff (rst)
    result_wr |-> $past(func_q) != FN_INVALID)
    else $error("invalid function wrote a result");
  chk_bit0_zero: assert property (@(posedge clock) disable iff (rst)
    ce && reg_rd_en && hit |=> reg_rdata[0] == RSVD_READ)
    else $error("reserved bit read nonzero");
  chk_field_readback: assert property (@(posedge clock) disable iff (rst)
    ce && wr_hit ##1 ce && reg_rd_en && hit |=>
    reg_rdata[FUNC_HI:RES_LO] == $past(reg_wdata[FUNC_HI:RES_LO], 2))
    else $error("function or resolution readback altered");
  chk_avg_count: assert property (@(posedge clock) disable iff (rst)
    result_wr && $stable(avg_q) |-> hcnt_q == avg_total(avg_q))
    else $error("averaged group has wrong conversion count");
  chk_drive_only: assert property (@(posedge clock) disable iff (rst)
    ce && st_q == ST_IDLE && !stop_q && func_q == FN_DRV_YX && !wr_hit
    |=> drv_en == DRV_YX && !conv_start)
    else $error("drive-only code wrong pattern");

endmodule : tac_control

// File: dv/tac_adc_model.sv
`timescale 1ns/1ps
// ************************************************************
// Converter stand-in
// ************************************************************
module tac_adc_model
  import tac_pkg::*;
#(
  parameter int DLY = 6
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_sel,
  output logic             conv_done,
  output logic      [11:0] conv_data
);
  int          cnt_q;
  logic [11:0] val_q;

  // Fixed latency; the sample carries its code so misrouting shows
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 0;
      val_q <= 12'h000;
    end
    else if (conv_start)
    begin
      cnt_q <= DLY;
      val_q <= {conv_sel, 8'ha5};
    end
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
  end

  // Off the pulse the bus shows the inverse, never a stale match
  assign conv_done = (cnt_q == 1);
  assign conv_data = conv_done ? val_q : ~val_q;
endmodule : tac_adc_model

// File: dv/tac_control_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
// ************************************************************
// Control register bench
// ************************************************************
module tac_control_bench
  import tac_pkg::*;
;
  logic        clock, rst, ce, pen_touch, reg_wr_en, reg_rd_en;
  logic [5:0]  reg_addr;
  logic [1:0]  reg_page, conv_res, conv_clock_sel;
  logic [15:0] reg_wdata, reg_rdata, rd_v;
  logic        conv_done, conv_start, adc_power_on, adc_busy, result_wr;
  logic [11:0] conv_data, result_data;
  logic [3:0]  conv_sel, drv_en, result_sel;
  logic [15:0] q[$];
  int          fails, checked, starts;

  // Only the settle code the bench uses is shrunk to keep runs short
  tac_control #(.SETTLE_100US_CYC(3)) u_tac_control (
    .clock(clock), .rst(rst), .ce(ce), .pen_touch(pen_touch),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .conv_sel(conv_sel), .conv_res(conv_res),
    .conv_clock_sel(conv_clock_sel), .adc_power_on(adc_power_on),
    .adc_busy(adc_busy), .drv_en(drv_en), .result_wr(result_wr),
    .result_sel(result_sel), .result_data(result_data));

  tac_adc_model u_tac_adc_model (.clock(clock), .rst(rst),
    .conv_start(conv_start), .conv_sel(conv_sel),
    .conv_done(conv_done), .conv_data(conv_data));

  // Free-running clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Result and start collector
  always @(posedge clock)
  begin
    if (result_wr === 1'b1)
      q.push_back({result_sel, result_data});
    if (conv_start === 1'b1)
      starts++;
  end

  task automatic wr(input logic [15:0] d, input logic [1:0] pg);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_wdata <= d;
    reg_page  <= pg;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] pg);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_page  <= pg;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(negedge clock);
    rd_v = reg_rdata;
  endtask : rd

  // Cleared off the edge so the collector never races it
  task automatic clr();
    @(negedge clock);
    q.delete();
    starts = 0;
  endtask : clr

  task automatic idle();
    repeat (3) @(negedge clock);
    for (int i = 0; i < 3000 && adc_busy !== 1'b0; i++)
      @(negedge clock);
    `CHK("busy", 1'b0, adc_busy)
    @(negedge clock); // Last result is collected one edge after busy drops
  endtask : idle

  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && q.size() < n; i++)
      @(negedge clock);
  endtask : wait_q

  // Packed {count, m0, m1, m2, m3} of results per function code
  function automatic logic [19:0] mlist(input int c);
    case (c)
      5:       return 20'h22300;
      11:      return 20'h44567;
      12:      return 20'h19000;
      default: return {4'h1, 4'((c < 6) ? c - 3 : c - 2), 12'h000};
    endcase
  endfunction : mlist

  task automatic t_regs();
    rd(CTRL_PAGE);
    `CHK("reset", 16'h4000, rd_v)
    wr(16'h4bff, CTRL_PAGE);
    rd(CTRL_PAGE);
    `CHK("readback", 16'h4bfe, rd_v)
    `CHK("clock sel", 2'h3, conv_clock_sel)
    wr(16'h0000, 2'h0);
    rd(2'h2);
    `CHK("unmapped read", 16'h4bfe, rd_v)
    rd(CTRL_PAGE);
    `CHK("unmapped write", 16'h4bfe, rd_v)
    @(posedge clock);
    ce <= 1'b0;
    wr(16'h0000, CTRL_PAGE);
    @(posedge clock);
    ce       <= 1'b1;
    reg_addr <= 6'h01;
    wr(16'h0000, CTRL_PAGE);
    @(posedge clock);
    reg_addr <= CTRL_ADDR;
    rd(CTRL_PAGE);
    `CHK("frozen or other address", 16'h4bfe, rd_v)
    // Write then read on the very next edge, no idle cycle between
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_wdata <= 16'h6a00;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(negedge clock);
    `CHK("back to back", 16'h6a00, reg_rdata)
    $display("test regs done");
  endtask : t_regs

  task automatic t_single();
    logic [19:0] e;
    logic [3:0]  m;
    for (int c = 3; c <= 12; c++)
    begin
      clr();
      wr({2'b00, 4'(c), 10'h000}, CTRL_PAGE);
      rd(CTRL_PAGE);
      `CHK("busy bit", 1'b0, rd_v[STOP_BIT])
      idle();
      e = mlist(c);
      `CHK("count", 32'(e[19:16]), 32'(q.size()))
      for (int i = 0; i < int'(e[19:16]); i++)
      begin
        m = e[15-4*i -: 4];
        `CHK("result", {m, m, 8'ha5}, q[i])
      end
    end
    $display("test single done");
  endtask : t_single

  task automatic t_res();
    logic [11:0] x;
    for (int r = 1; r <= 3; r++)
    begin
      clr();
      wr({6'h06, 2'(r), 8'h40}, CTRL_PAGE);
      idle();
      x = (r == 1) ? 12'h04a : (r == 2) ? 12'h129 : 12'h4a5;
      `CHK("res", 2'(r), conv_res)
      `CHK("avg starts", 4, starts)
      `CHK("scaled", {4'h4, x}, q[0])
    end
    $display("test res done");
  endtask : t_res

  task automatic t_scan();
    @(posedge clock);
    pen_touch <= 1'b1;
    repeat (4) @(posedge clock);
    rd(CTRL_PAGE);
    `CHK("pen", 1'b1, rd_v[PEN_BIT])
    clr();
    wr(16'h0400, CTRL_PAGE);
    wait_q(5);
    for (int i = 0; i < 5; i++)
      `CHK("xy", 4'(i % 2), q[i][15:12])
    wr(16'h4400, CTRL_PAGE);
    repeat (2) @(negedge clock);
    `CHK("stop busy", 1'b0, adc_busy)
    `CHK("stop power", 1'b0, adc_power_on)
    clr();
    repeat (30) @(negedge clock);
    `CHK("stopped", 0, starts + q.size())
    wr(16'h0800, CTRL_PAGE);
    wait_q(6);
    for (int i = 0; i < 6; i++)
      `CHK("xyz", 4'(i % 4), q[i][15:12])
    @(posedge clock);
    pen_touch <= 1'b0;
    idle();
    $display("test scan done");
  endtask : t_scan

  task automatic t_misc();
    for (int c = 13; c <= 15; c++)
    begin
      clr();
      wr({2'b00, 4'(c), 10'h000}, CTRL_PAGE);
      repeat (2) @(negedge clock);
      `CHK("drv", c == 13 ? DRV_X : c == 14 ? DRV_Y : DRV_YX, drv_en)
      `CHK("drv starts", 0, starts)
    end
    wr(16'h4000, CTRL_PAGE);
    repeat (2) @(negedge clock);
    `CHK("drv off", DRV_OFF, drv_en)
    clr();
    wr(16'h0000, CTRL_PAGE);
    repeat (10) @(negedge clock);
    `CHK("invalid", 0, starts + q.size())
    wr(16'h8c02, CTRL_PAGE);
    repeat (10) @(negedge clock);
    `CHK("armed", 0, q.size())
    @(posedge clock);
    pen_touch <= 1'b1;
    repeat (7) @(negedge clock);
    `CHK("settle wait", 0, starts)
    wait_q(1);
    `CHK("self x", 4'h0, q[0][15:12])
    wr(16'h4000, CTRL_PAGE);
    @(posedge clock);
    pen_touch <= 1'b0;
    $display("test misc done");
  endtask : t_misc

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    rst       = 1'b1;
    ce        = 1'b1;
    reg_addr  = CTRL_ADDR;
    pen_touch = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_page  = 2'h0;
    reg_wdata = 16'h0000;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_res();
    t_scan();
    t_misc();
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #1_000_000;
    fails++;
    close_out();
  end
endmodule : tac_control_bench
